// ### common/sksx_pkg.sv
// Shared constants, opcodes, register map and states for the skip/sub/swap/table/xor unit
package sksx_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int DM_AW  = 6;
	localparam int PA_W   = 16;
	localparam int PD_W   = 16;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] REG_CMD      = 8'h00;
	localparam logic [ADDR_W-1:0] REG_ACC      = 8'h04;
	localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h08;
	localparam logic [ADDR_W-1:0] REG_TBL_LOW  = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_TBL_HIGH = 8'h10;
	localparam logic [ADDR_W-1:0] REG_TBL_BYTE = 8'h14;
	localparam logic [ADDR_W-1:0] REG_MEM_ADDR = 8'h18;
	localparam logic [ADDR_W-1:0] REG_MEM_DATA = 8'h1c;

	// Command register fields
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_BIT_LSB  = 4;
	localparam int CMD_ADDR_LSB = 8;
	localparam int CMD_IMM_LSB  = 16;
	localparam int CMD_GO_BIT   = 31;

	// Status register fields
	localparam int ST_CARRY  = 0;
	localparam int ST_NIBBLE = 1;
	localparam int ST_ZERO   = 2;
	localparam int ST_WRAP   = 3;
	localparam int ST_BUSY   = 8;
	localparam int ST_SKIP   = 9;

	// Final program page when only the low pointer is used
	localparam logic [7:0] LAST_PAGE = 8'hff;

	// Opcodes
	localparam logic [3:0] OP_INCR_SKIP_IF_ZERO        = 4'h0;
	localparam logic [3:0] OP_INCR_TO_ACC_SKIP_IF_ZERO = 4'h1;
	localparam logic [3:0] OP_BIT_SET_SKIP             = 4'h2;
	localparam logic [3:0] OP_MINUS_TO_ACC             = 4'h3;
	localparam logic [3:0] OP_MINUS_TO_MEM             = 4'h4;
	localparam logic [3:0] OP_MINUS_IMM                = 4'h5;
	localparam logic [3:0] OP_NIBBLE_EXCHANGE          = 4'h6;
	localparam logic [3:0] OP_NIBBLE_EXCHANGE_TO_ACC   = 4'h7;
	localparam logic [3:0] OP_ZERO_TEST_SKIP           = 4'h8;
	localparam logic [3:0] OP_COPY_ZERO_TEST_SKIP      = 4'h9;
	localparam logic [3:0] OP_BIT_CLEAR_SKIP           = 4'ha;
	localparam logic [3:0] OP_TABLE_FETCH              = 4'hb;
	localparam logic [3:0] OP_LAST_PAGE_TABLE_FETCH    = 4'hc;
	localparam logic [3:0] OP_EXCLUSIVE_OR_TO_ACC      = 4'hd;
	localparam logic [3:0] OP_EXCLUSIVE_OR_TO_MEM      = 4'he;
	localparam logic [3:0] OP_EXCLUSIVE_OR_IMM         = 4'hf;

	typedef enum logic [4:0] {
		S_IDLE  = 5'h01,
		S_READ  = 5'h02,
		S_EXEC  = 5'h04,
		S_TABLE = 5'h08,
		S_DUMMY = 5'h10
	} sksx_state_e;
endpackage

// ### core/sksx_dmem.sv
// Single-port data memory with registered read data
module sksx_dmem #(
	parameter int AW = 6,
	parameter int DW = 8
) (
	input  wire logic          pclk,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	output logic      [DW-1:0] rdata_ff
);
	logic [DW-1:0] mem_ff [0:(1<<AW)-1];

	always_ff @(posedge pclk) begin
		if (we) begin
			mem_ff[addr] <= wdata;
		end
		rdata_ff <= mem_ff[addr];
	end
endmodule

// ### core/sksx_core.sv
// Execution unit for skip, subtract, nibble exchange, table fetch and xor instructions
// Functional notes
// - Increment memory byte, skip when result zero
// - Increment into accumulator, memory unchanged, skip zero
// - Taken skips add dummy cycle; flags untouched
// - Skip when selected bit is one
// - Accumulator minus memory into accumulator, four flags
// - Carry cleared on borrow, set otherwise
// - Accumulator minus memory written back to memory
// - Accumulator minus immediate into accumulator
// - Exchange nibbles of memory byte in place
// - Exchanged nibbles to accumulator, memory unchanged
// - Skip when whole memory byte is zero
// - Copy byte to accumulator, skip if zero
// - Skip when selected bit is zero
// - Table word at full pointer to memory/high
// - Last-page table word using low pointer only
// - Xor memory into accumulator, zero flag only
// - Xor result written to memory, zero only
// - Xor immediate into accumulator, zero only
//
// Our own choices: the APB slave port and the placing of the registers.
module sksx_core
	import sksx_pkg::*;
(
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [sksx_pkg::ADDR_W-1:0] paddr,
	input  wire logic [sksx_pkg::DATA_W-1:0] pwdata,
	output logic      [sksx_pkg::DATA_W-1:0] prdata,
	output logic                             pready,
	output logic                             pslverr,
	output logic      [sksx_pkg::PA_W-1:0]   prog_addr_ff,
	output logic                             prog_rd_ff,
	input  wire logic [sksx_pkg::PD_W-1:0]   prog_data,
	output logic                             skip_req_ff,
	output logic                             exec_done_ff
);
	import sksx_pkg::*;

	sksx_state_e       state_ff;
	sksx_state_e       nxt_state;
	logic [3:0]        op_ff;
	logic [2:0]        bit_ff;
	logic [DM_AW-1:0]  addr_ff;
	logic [7:0]        imm_ff;
	logic [7:0]        acc_ff;
	logic              carry_ff;
	logic              nibble_ff;
	logic              zero_ff;
	logic              wrap_ff;
	logic              skip_seen_ff;
	logic [7:0]        tbl_low_ff;
	logic [7:0]        tbl_high_ff;
	logic [7:0]        tbl_byte_ff;
	logic [DM_AW-1:0]  mem_addr_ff;
	logic              rd_wait_ff;
	logic [7:0]        mem_rdata;
	logic [7:0]        mem_wdata;
	logic [DM_AW-1:0]  mem_addr;
	logic              mem_we;

	logic              busy;
	logic              apb_acc;
	logic              apb_wr;
	logic              is_mem_data;
	logic              mapped;
	logic              go;

	logic [7:0]        sub_b;
	logic [8:0]        sub_full;
	logic [4:0]        sub_low;
	logic [7:0]        sub_res;
	logic [7:0]        inc_res;
	logic [7:0]        swap_res;
	logic [7:0]        xor_b;
	logic [7:0]        xor_res;
	logic              sel_bit;
	logic              is_sub;
	logic              is_xor;
	logic              is_skip_op;
	logic              skip_cond;
	logic              exec_we;
	logic [7:0]        exec_wdata;

	sksx_dmem #(
		.AW (DM_AW),
		.DW (8)
	) u_dmem (
		.pclk     (pclk),
		.we       (mem_we),
		.addr     (mem_addr),
		.wdata    (mem_wdata),
		.rdata_ff (mem_rdata)
	);

	assign busy        = (state_ff != S_IDLE);
	assign apb_acc     = psel & penable;
	assign is_mem_data = (paddr == REG_MEM_DATA);
	assign mapped      = (paddr == REG_CMD) | (paddr == REG_ACC) | (paddr == REG_STATUS)
		| (paddr == REG_TBL_LOW) | (paddr == REG_TBL_HIGH) | (paddr == REG_TBL_BYTE)
		| (paddr == REG_MEM_ADDR) | is_mem_data;
	// Memory port is shared, so data window accesses stall while executing
	assign pready  = ~is_mem_data | (~busy & (pwrite | rd_wait_ff));
	assign pslverr = apb_acc & pready & ~mapped;
	// Register writes are ignored while busy, so hardware and software never collide
	assign apb_wr  = apb_acc & pready & pwrite & ~busy;
	assign go      = apb_wr & (paddr == REG_CMD) & pwdata[CMD_GO_BIT];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_wait_ff <= 1'b0;
		end else begin
			rd_wait_ff <= apb_acc & is_mem_data & ~pwrite & ~busy & ~rd_wait_ff;
		end
	end

	always_comb begin
		prdata = '0;
		case (paddr)
			REG_CMD: begin
				prdata[CMD_OP_LSB +: 4]      = op_ff;
				prdata[CMD_BIT_LSB +: 3]     = bit_ff;
				prdata[CMD_ADDR_LSB +: DM_AW] = addr_ff;
				prdata[CMD_IMM_LSB +: 8]     = imm_ff;
			end
			REG_ACC:      prdata[7:0] = acc_ff;
			REG_STATUS: begin
				prdata[ST_CARRY]  = carry_ff;
				prdata[ST_NIBBLE] = nibble_ff;
				prdata[ST_ZERO]   = zero_ff;
				prdata[ST_WRAP]   = wrap_ff;
				prdata[ST_BUSY]   = busy;
				prdata[ST_SKIP]   = skip_seen_ff;
			end
			REG_TBL_LOW:  prdata[7:0] = tbl_low_ff;
			REG_TBL_HIGH: prdata[7:0] = tbl_high_ff;
			REG_TBL_BYTE: prdata[7:0] = tbl_byte_ff;
			REG_MEM_ADDR: prdata[DM_AW-1:0] = mem_addr_ff;
			REG_MEM_DATA: prdata[7:0] = mem_rdata;
			default:      prdata = '0;
		endcase
	end

	// Datapath
	assign is_sub     = (op_ff == OP_MINUS_TO_ACC) | (op_ff == OP_MINUS_TO_MEM)
		| (op_ff == OP_MINUS_IMM);
	assign is_xor     = (op_ff == OP_EXCLUSIVE_OR_TO_ACC) | (op_ff == OP_EXCLUSIVE_OR_TO_MEM)
		| (op_ff == OP_EXCLUSIVE_OR_IMM);
	assign sub_b      = (op_ff == OP_MINUS_IMM) ? imm_ff : mem_rdata;
	assign sub_full   = {1'b0, acc_ff} - {1'b0, sub_b};
	assign sub_low    = {1'b0, acc_ff[3:0]} - {1'b0, sub_b[3:0]};
	assign sub_res    = sub_full[7:0];
	assign inc_res    = mem_rdata + 8'h01;
	assign swap_res   = {mem_rdata[3:0], mem_rdata[7:4]};
	assign xor_b      = (op_ff == OP_EXCLUSIVE_OR_IMM) ? imm_ff : mem_rdata;
	assign xor_res    = acc_ff ^ xor_b;
	assign sel_bit    = mem_rdata[bit_ff];

	always_comb begin
		is_skip_op = 1'b1;
		skip_cond  = 1'b0;
		case (op_ff)
			OP_INCR_SKIP_IF_ZERO:        skip_cond = (inc_res == 8'h00);
			OP_INCR_TO_ACC_SKIP_IF_ZERO: skip_cond = (inc_res == 8'h00);
			OP_BIT_SET_SKIP:             skip_cond = sel_bit;
			OP_ZERO_TEST_SKIP:           skip_cond = (mem_rdata == 8'h00);
			OP_COPY_ZERO_TEST_SKIP:      skip_cond = (mem_rdata == 8'h00);
			OP_BIT_CLEAR_SKIP:           skip_cond = ~sel_bit;
			default:                     is_skip_op = 1'b0;
		endcase
	end

	always_comb begin
		exec_we    = 1'b0;
		exec_wdata = 8'h00;
		case (op_ff)
			OP_INCR_SKIP_IF_ZERO: begin
				exec_we    = 1'b1;
				exec_wdata = inc_res;
			end
			OP_MINUS_TO_MEM: begin
				exec_we    = 1'b1;
				exec_wdata = sub_res;
			end
			OP_NIBBLE_EXCHANGE: begin
				exec_we    = 1'b1;
				exec_wdata = swap_res;
			end
			OP_TABLE_FETCH, OP_LAST_PAGE_TABLE_FETCH: begin
				exec_we    = 1'b1;
				exec_wdata = prog_data[7:0];
			end
			OP_EXCLUSIVE_OR_TO_MEM: begin
				exec_we    = 1'b1;
				exec_wdata = xor_res;
			end
			default: begin
				exec_we    = 1'b0;
				exec_wdata = 8'h00;
			end
		endcase
	end

	assign mem_addr  = busy ? addr_ff : mem_addr_ff;
	assign mem_we    = (state_ff == S_EXEC) ? exec_we : (apb_wr & is_mem_data);
	assign mem_wdata = (state_ff == S_EXEC) ? exec_wdata : pwdata[7:0];

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			S_IDLE: begin
				if (go) begin
					if ((pwdata[CMD_OP_LSB +: 4] == OP_TABLE_FETCH)
						|| (pwdata[CMD_OP_LSB +: 4] == OP_LAST_PAGE_TABLE_FETCH)) begin
						nxt_state = S_TABLE;
					end else begin
						nxt_state = S_READ;
					end
				end
			end
			S_READ:  nxt_state = S_EXEC;
			S_TABLE: nxt_state = S_EXEC;
			// Dummy slot stands in for the fetch that a taken skip throws away
			S_EXEC:  nxt_state = (is_skip_op & skip_cond) ? S_DUMMY : S_IDLE;
			S_DUMMY: nxt_state = S_IDLE;
			default: nxt_state = S_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= S_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_ff   <= OP_INCR_SKIP_IF_ZERO;
			bit_ff  <= 3'h0;
			addr_ff <= '0;
			imm_ff  <= 8'h00;
		end else if (apb_wr && (paddr == REG_CMD)) begin
			op_ff   <= pwdata[CMD_OP_LSB +: 4];
			bit_ff  <= pwdata[CMD_BIT_LSB +: 3];
			addr_ff <= pwdata[CMD_ADDR_LSB +: DM_AW];
			imm_ff  <= pwdata[CMD_IMM_LSB +: 8];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_ff <= 8'h00;
		end else if (apb_wr && (paddr == REG_ACC)) begin
			acc_ff <= pwdata[7:0];
		end else if (state_ff == S_EXEC) begin
			case (op_ff)
				OP_INCR_TO_ACC_SKIP_IF_ZERO: acc_ff <= inc_res;
				OP_MINUS_TO_ACC:             acc_ff <= sub_res;
				OP_MINUS_IMM:                acc_ff <= sub_res;
				OP_NIBBLE_EXCHANGE_TO_ACC:   acc_ff <= swap_res;
				OP_COPY_ZERO_TEST_SKIP:      acc_ff <= mem_rdata;
				OP_EXCLUSIVE_OR_TO_ACC:      acc_ff <= xor_res;
				OP_EXCLUSIVE_OR_IMM:         acc_ff <= xor_res;
				default:                     acc_ff <= acc_ff;
			endcase
		end
	end

	// Only subtract and xor touch flags; everything else leaves them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			carry_ff  <= 1'b0;
			nibble_ff <= 1'b0;
			zero_ff   <= 1'b0;
			wrap_ff   <= 1'b0;
		end else if (apb_wr && (paddr == REG_STATUS)) begin
			carry_ff  <= pwdata[ST_CARRY];
			nibble_ff <= pwdata[ST_NIBBLE];
			zero_ff   <= pwdata[ST_ZERO];
			wrap_ff   <= pwdata[ST_WRAP];
		end else if ((state_ff == S_EXEC) && is_sub) begin
			carry_ff  <= ~sub_full[8];
			nibble_ff <= ~sub_low[4];
			zero_ff   <= (sub_res == 8'h00);
			wrap_ff   <= (acc_ff[7] != sub_b[7]) && (sub_res[7] != acc_ff[7]);
		end else if ((state_ff == S_EXEC) && is_xor) begin
			zero_ff   <= (xor_res == 8'h00);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tbl_low_ff  <= 8'h00;
			tbl_high_ff <= 8'h00;
			mem_addr_ff <= '0;
		end else if (apb_wr) begin
			if (paddr == REG_TBL_LOW) begin
				tbl_low_ff <= pwdata[7:0];
			end
			if (paddr == REG_TBL_HIGH) begin
				tbl_high_ff <= pwdata[7:0];
			end
			if (paddr == REG_MEM_ADDR) begin
				mem_addr_ff <= pwdata[DM_AW-1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_addr_ff <= '0;
			prog_rd_ff   <= 1'b0;
		end else begin
			prog_rd_ff <= go && (nxt_state == S_TABLE);
			if (go && (pwdata[CMD_OP_LSB +: 4] == OP_TABLE_FETCH)) begin
				prog_addr_ff <= {tbl_high_ff, tbl_low_ff};
			end else if (go && (pwdata[CMD_OP_LSB +: 4] == OP_LAST_PAGE_TABLE_FETCH)) begin
				prog_addr_ff <= {LAST_PAGE, tbl_low_ff};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tbl_byte_ff <= 8'h00;
		end else if ((state_ff == S_EXEC)
			&& ((op_ff == OP_TABLE_FETCH) || (op_ff == OP_LAST_PAGE_TABLE_FETCH))) begin
			tbl_byte_ff <= prog_data[15:8];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			skip_req_ff  <= 1'b0;
			exec_done_ff <= 1'b0;
			skip_seen_ff <= 1'b0;
		end else begin
			skip_req_ff  <= (state_ff == S_EXEC) && is_skip_op && skip_cond;
			exec_done_ff <= (nxt_state == S_IDLE) && busy;
			if (state_ff == S_EXEC) begin
				skip_seen_ff <= is_skip_op && skip_cond;
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_exec_op(logic [3:0] op);
		(state_ff == S_EXEC) && (op_ff == op);
	endsequence

	sequence s_skip_taken;
		(state_ff == S_EXEC) && is_skip_op && skip_cond;
	endsequence

	a_inc_mem_write: assert property (s_exec_op(OP_INCR_SKIP_IF_ZERO) |-> mem_we &&
		(mem_wdata == mem_rdata + 8'h01)) else $error("increment not written back");
	a_inc_acc_only: assert property (s_exec_op(OP_INCR_TO_ACC_SKIP_IF_ZERO) |-> !mem_we
		##1 (acc_ff == $past(mem_rdata) + 8'h01)) else $error("increment to acc wrong");
	a_skip_two_cyc: assert property (s_skip_taken |=> (state_ff == S_DUMMY) && skip_req_ff
		##1 (state_ff == S_IDLE) && exec_done_ff) else $error("taken skip not two cycles");
	a_flags_kept: assert property ((state_ff == S_EXEC) && !is_sub && !is_xor
		|=> $stable({carry_ff, nibble_ff, zero_ff, wrap_ff})) else $error("flags changed");
	a_bit_set_skip: assert property (s_exec_op(OP_BIT_SET_SKIP) |=>
		(skip_req_ff == $past(mem_rdata[bit_ff]))) else $error("bit set skip wrong");
	a_sub_acc_val: assert property (s_exec_op(OP_MINUS_TO_ACC) |=>
		(acc_ff == $past(acc_ff) - $past(mem_rdata))) else $error("subtract result wrong");
	a_sub_carry: assert property ((state_ff == S_EXEC) && is_sub |=>
		(carry_ff == ($past(acc_ff) >= $past(sub_b)))) else $error("carry wrong");
	a_minus_to_mem_mem: assert property (s_exec_op(OP_MINUS_TO_MEM) |-> mem_we &&
		(mem_wdata == acc_ff - mem_rdata)) else $error("subtract to mem wrong");
	a_sub_imm: assert property (s_exec_op(OP_MINUS_IMM) |=>
		(acc_ff == $past(acc_ff) - $past(imm_ff))) else $error("immediate subtract wrong");
	a_swap_mem: assert property (s_exec_op(OP_NIBBLE_EXCHANGE) |-> mem_we &&
		(mem_wdata == {mem_rdata[3:0], mem_rdata[7:4]})) else $error("swap wrong");
	a_swap_acc: assert property (s_exec_op(OP_NIBBLE_EXCHANGE_TO_ACC) |-> !mem_we ##1
		(acc_ff == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})) else $error("swap acc");
	a_zero_skip: assert property (s_exec_op(OP_ZERO_TEST_SKIP) |=>
		(skip_req_ff == ($past(mem_rdata) == 8'h00))) else $error("zero skip wrong");
	a_copy_skip: assert property (s_exec_op(OP_COPY_ZERO_TEST_SKIP) |=>
		(acc_ff == $past(mem_rdata))) else $error("copy test wrong");
	a_bit_clr_skip: assert property (s_exec_op(OP_BIT_CLEAR_SKIP) |=>
		(skip_req_ff != $past(mem_rdata[bit_ff]))) else $error("bit clear skip wrong");
	a_table_full: assert property ((state_ff == S_TABLE) && (op_ff == OP_TABLE_FETCH) |->
		(prog_addr_ff == {tbl_high_ff, tbl_low_ff}) ##1 mem_we ##1
		(tbl_byte_ff == $past(prog_data[15:8]))) else $error("table fetch wrong");
	a_table_last: assert property ((state_ff == S_TABLE)
		&& (op_ff == OP_LAST_PAGE_TABLE_FETCH) |-> (prog_addr_ff == {LAST_PAGE, tbl_low_ff}))
		else $error("last page address wrong");
	a_xor_zero: assert property ((state_ff == S_EXEC) && is_xor |=>
		(zero_ff == ($past(xor_res) == 8'h00)) && $stable({carry_ff, nibble_ff, wrap_ff}))
		else $error("xor flags wrong");
	a_sub_wrap: assert property ((state_ff == S_EXEC) && is_sub |=> (wrap_ff ==
		($past(acc_ff[7]) != $past(sub_b[7]) && $past(sub_res[7]) != $past(acc_ff[7]))))
		else $error("wrap flag wrong");
endmodule

// ### testbench/sksx_prog_model.sv
// Program memory stand-in that answers table fetch reads
module sksx_prog_model
	import sksx_pkg::*;
(
	input  wire logic                      pclk,
	input  wire logic [sksx_pkg::PA_W-1:0] prog_addr_ff,
	input  wire logic                      prog_rd_ff,
	output logic      [sksx_pkg::PD_W-1:0] prog_data
);
	timeunit 1ns;
	timeprecision 1ps;

	initial prog_data = 16'h0000;

	// Word valid only in the cycle after a read pulse, churns otherwise
	always @(posedge pclk) begin
		if (prog_rd_ff) begin
			prog_data <= {prog_addr_ff[7:0] ^ 8'h3c, prog_addr_ff[15:8] ^ 8'ha5};
		end else begin
			prog_data <= ~prog_data;
		end
	end
endmodule

// ### testbench/tb_skip_sub_swap_table_xor_exec.sv
// Self-checking bench for the skip, subtract, exchange, table and xor unit
module tb_skip_sub_swap_table_xor_exec;
	timeunit 1ns;
	timeprecision 1ps;
	import sksx_pkg::*;

	typedef struct packed {
		logic [3:0] op;
		logic [2:0] b;
		logic [7:0] m, a, imm;
		logic [3:0] f;
		logic [7:0] ea, em;
		logic [3:0] ef;
		logic       sk;
	} sksx_row_s;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [15:0] prog_addr_ff, prog_data;
	logic        prog_rd_ff, skip_req_ff, exec_done_ff, errv, sk;
	int          fail_count, compares, cyc;
	sksx_row_s   r;

	// Fields: op, bit, mem, acc, imm, flags, exp acc, exp mem, exp flags, exp skip
	sksx_row_s rows [21] = '{
		'{OP_INCR_SKIP_IF_ZERO, 3'h0, 8'hff, 8'h12, 8'h00, 4'h5, 8'h12, 8'h00, 4'h5, 1'b1},
		'{OP_INCR_SKIP_IF_ZERO, 3'h0, 8'h7f, 8'h12, 8'h00, 4'ha, 8'h12, 8'h80, 4'ha, 1'b0},
		'{OP_INCR_TO_ACC_SKIP_IF_ZERO, 3'h0, 8'hff, 8'h33, 8'h00, 4'ha, 8'h00, 8'hff, 4'ha, 1'b1},
		'{OP_INCR_TO_ACC_SKIP_IF_ZERO, 3'h0, 8'h41, 8'h33, 8'h00, 4'h5, 8'h42, 8'h41, 4'h5, 1'b0},
		'{OP_BIT_SET_SKIP, 3'h7, 8'h80, 8'h5a, 8'h00, 4'h5, 8'h5a, 8'h80, 4'h5, 1'b1},
		'{OP_BIT_SET_SKIP, 3'h0, 8'hfe, 8'h5a, 8'h00, 4'ha, 8'h5a, 8'hfe, 4'ha, 1'b0},
		'{OP_MINUS_TO_ACC, 3'h0, 8'h07, 8'h05, 8'h00, 4'hf, 8'hfe, 8'h07, 4'h0, 1'b0},
		'{OP_MINUS_TO_ACC, 3'h0, 8'h01, 8'h80, 8'h00, 4'h0, 8'h7f, 8'h01, 4'h9, 1'b0},
		'{OP_MINUS_TO_MEM, 3'h0, 8'h33, 8'h33, 8'h00, 4'h8, 8'h33, 8'h00, 4'h7, 1'b0},
		'{OP_MINUS_IMM, 3'h0, 8'h99, 8'h10, 8'h20, 4'hf, 8'hf0, 8'h99, 4'h2, 1'b0},
		'{OP_NIBBLE_EXCHANGE, 3'h0, 8'ha5, 8'h11, 8'h00, 4'h5, 8'h11, 8'h5a, 4'h5, 1'b0},
		'{OP_NIBBLE_EXCHANGE_TO_ACC, 3'h0, 8'h3c, 8'h00, 8'h00, 4'ha, 8'hc3, 8'h3c, 4'ha, 1'b0},
		'{OP_ZERO_TEST_SKIP, 3'h0, 8'h00, 8'h77, 8'h00, 4'h5, 8'h77, 8'h00, 4'h5, 1'b1},
		'{OP_ZERO_TEST_SKIP, 3'h0, 8'h01, 8'h77, 8'h00, 4'ha, 8'h77, 8'h01, 4'ha, 1'b0},
		'{OP_COPY_ZERO_TEST_SKIP, 3'h0, 8'h00, 8'h77, 8'h00, 4'ha, 8'h00, 8'h00, 4'ha, 1'b1},
		'{OP_COPY_ZERO_TEST_SKIP, 3'h0, 8'h42, 8'h00, 8'h00, 4'h5, 8'h42, 8'h42, 4'h5, 1'b0},
		'{OP_BIT_CLEAR_SKIP, 3'h3, 8'hf7, 8'h00, 8'h00, 4'h5, 8'h00, 8'hf7, 4'h5, 1'b1},
		'{OP_BIT_CLEAR_SKIP, 3'h4, 8'h10, 8'h00, 8'h00, 4'ha, 8'h00, 8'h10, 4'ha, 1'b0},
		'{OP_EXCLUSIVE_OR_TO_ACC, 3'h0, 8'hf0, 8'hf0, 8'h00, 4'hb, 8'h00, 8'hf0, 4'hf, 1'b0},
		'{OP_EXCLUSIVE_OR_TO_MEM, 3'h0, 8'hf0, 8'h0f, 8'h00, 4'h4, 8'h0f, 8'hff, 4'h0, 1'b0},
		'{OP_EXCLUSIVE_OR_IMM, 3'h0, 8'h66, 8'h55, 8'haa, 4'hd, 8'hff, 8'h66, 4'h9, 1'b0}
	};

	sksx_core DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.prog_addr_ff(prog_addr_ff), .prog_rd_ff(prog_rd_ff), .prog_data(prog_data),
		.skip_req_ff(skip_req_ff), .exec_done_ff(exec_done_ff)
	);

	sksx_prog_model prog_mem (
		.pclk(pclk), .prog_addr_ff(prog_addr_ff), .prog_rd_ff(prog_rd_ff), .prog_data(prog_data)
	);

	always #5 pclk = ~pclk;

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Request held until pready is seen at a rising edge; data taken at that same edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle memory window reads owe one wait state, everything else none
		chk("pready", 32'(n), (a == REG_MEM_DATA && !wr) ? 32'h2 : 32'h1);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic wait_done();
		cyc = 0;
		sk = 1'b0;
		do begin
			@(negedge pclk);
			cyc++;
			if (skip_req_ff === 1'b1) sk = 1'b1;
		end while (exec_done_ff !== 1'b1 && cyc < 20);
	endtask

	task automatic run(input logic [3:0] op, input logic [2:0] b, input logic [5:0] a,
			input logic [7:0] imm);
		wr(REG_CMD, {1'b1, 7'h00, imm, 2'b00, a, 1'b0, b, op});
		wait_done();
	endtask

	task automatic stop_test();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#100000;
		fail_count++;
		stop_test();
	end

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		fail_count = 0;
		compares = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			r = rows[i];
			wr(REG_MEM_ADDR, 32'(i));
			wr(REG_MEM_DATA, {24'h0, r.m});
			wr(REG_ACC, {24'h0, r.a});
			wr(REG_STATUS, {28'h0, r.f});
			run(r.op, r.b, 6'(i), r.imm);
			chk("skip", {31'h0, sk}, {31'h0, r.sk});
			chk("cycles", 32'(cyc), r.sk ? 32'h4 : 32'h3);
			rd(REG_ACC);
			chk("acc", rdv, {24'h0, r.ea});
			rd(REG_MEM_DATA);
			chk("mem", rdv, {24'h0, r.em});
			rd(REG_STATUS);
			chk("flags", {28'h0, rdv[3:0]}, {28'h0, r.ef});
			chk("last skip", {31'h0, rdv[9]}, {31'h0, r.sk});
		end
		// Table fetch with both pointers, then last page with the low pointer only
		wr(REG_TBL_HIGH, 32'h12);
		wr(REG_TBL_LOW, 32'h34);
		wr(REG_STATUS, 32'h5);
		run(OP_TABLE_FETCH, 3'h0, 6'h30, 8'h00);
		wr(REG_MEM_ADDR, 32'h30);
		rd(REG_MEM_DATA);
		chk("table low", rdv, 32'hb7);
		rd(REG_TBL_BYTE);
		chk("table high", rdv, 32'h08);
		wr(REG_TBL_LOW, 32'h9a);
		run(OP_LAST_PAGE_TABLE_FETCH, 3'h0, 6'h31, 8'h00);
		wr(REG_MEM_ADDR, 32'h31);
		rd(REG_MEM_DATA);
		chk("page low", rdv, 32'h5a);
		rd(REG_TBL_BYTE);
		chk("page high", rdv, 32'ha6);
		rd(REG_STATUS);
		chk("table flags", {28'h0, rdv[3:0]}, 32'h5);
		// Unmapped place answers with an error and reads zero
		rd(8'h20);
		chk("unmapped err", {31'h0, errv}, 32'h1);
		chk("unmapped data", rdv, 32'h0);
		// Taken skip on a zero byte keeps the unit busy while the next write lands
		wr(REG_ACC, 32'h11);
		wr(REG_CMD, {1'b1, 7'h00, 8'h00, 2'b00, 6'h00, 1'b0, 3'h0, OP_ZERO_TEST_SKIP});
		wr(REG_ACC, 32'hee);
		wait_done();
		rd(REG_ACC);
		chk("busy write", rdv, 32'h11);
		// Reset in mid-instruction returns the accumulator, status, table byte and low pointer to zero
		wr(REG_CMD, {1'b1, 7'h00, 8'h00, 2'b00, 6'h03, 1'b0, 3'h0, OP_INCR_SKIP_IF_ZERO});
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(REG_ACC);
		chk("reset acc", rdv, 32'h0);
		rd(REG_STATUS);
		chk("reset status", rdv, 32'h0);
		rd(REG_TBL_BYTE);
		chk("reset table", rdv, 32'h0);
		rd(REG_TBL_LOW);
		chk("reset pointer", rdv, 32'h0);
		stop_test();
	end
endmodule
